// *** rtl/hcpu_defines.vh ***
// Purpose: constants for the hall commutation pwm unit
// Assumes: 25 MHz system clock, APB with 32-bit data
// Notes:   offsets are byte addresses
`ifndef HCPU_DEFINES_VH
`define HCPU_DEFINES_VH

// clock and times
`define HCPU_CLK_MHZ        25
`define HCPU_CARRIER_US     50
`define HCPU_TICK_US        1000
`define HCPU_STALL_US       20000

// register byte offsets
`define HCPU_ADDR_CTRL      12'h000
`define HCPU_ADDR_OUTSEL    12'h004
`define HCPU_ADDR_OUTLEVEL  12'h008
`define HCPU_ADDR_DUTY      12'h00C
`define HCPU_ADDR_STATUS    12'h010
`define HCPU_ADDR_IRQSTAT   12'h014
`define HCPU_ADDR_IRQMASK   12'h018
`define HCPU_ADDR_SPEEDCNT  12'h01C
`define HCPU_ADDR_SPEEDCAP  12'h020

// control fields
`define HCPU_CTRL_RUN       0
`define HCPU_CTRL_AUTO      1
`define HCPU_CTRL_SDCLR     2
`define HCPU_CTRL_STCLR     3

// status fields
`define HCPU_ST_HALL_LSB    0
`define HCPU_ST_SHUTDOWN    3
`define HCPU_ST_STALL       4
`define HCPU_ST_OCPIN       5

// interrupt status fields
`define HCPU_IRQ_TICK       0
`define HCPU_IRQ_CARRIER    1
`define HCPU_IRQ_HALLU      2
`define HCPU_IRQ_HALLV      3
`define HCPU_IRQ_HALLW      4
`define HCPU_IRQ_OC         5
`define HCPU_IRQ_STALL      6
`define HCPU_IRQ_W          7

// reset values
`define HCPU_RST_CTRL       4'h0
`define HCPU_RST_OUTSEL     6'h00
`define HCPU_RST_OUTLEVEL   6'h00
`define HCPU_RST_DUTY       11'h000
`define HCPU_RST_IRQMASK    7'h00

`endif

// *** rtl/hcpu_hall_commutation_pwm_unit.v ***
// Purpose: timers, six-signal pwm drive, hall and overcurrent events
// Assumes: all inputs synchronous to clk, APB slave with zero wait
// Notes:   switch index 0..5 = U-high, U-low, V-high, V-low, W-high, W-low
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "hcpu_defines.vh"

// Notes on behaviour
// - timer channel 0 raises an interrupt every 1 ms as control tick.
// - timer channel 1 counts freely without interrupt; sampled at hall edges.
// - sawtooth carrier gives six outputs, complementary, no dead time.
// - pwm outputs are active high; carrier period is 50 us.
// - overcurrent input low puts all pwm-producing pins into high impedance.
// - overcurrent input raises its interrupt on a falling edge.
// - each hall input raises its own interrupt on both edges.
// - hall inputs are readable as plain levels in the status register.
// - each switch signal is driven by static level or pwm, chosen per signal.
// - U-high u0 B, U-low u0 D, V-high u1 A, V-low u1 C, W u1 B/D.
// - the pwm timer raises a carrier interrupt once per carrier period.
// - no hall edge for 20 ms while driving disables all six outputs.
module hcpu_hall_commutation_pwm_unit #(
  parameter TICK_CYCLES  = `HCPU_TICK_US * `HCPU_CLK_MHZ,
  parameter STALL_CYCLES = `HCPU_STALL_US * `HCPU_CLK_MHZ
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // hall sensors and overcurrent
  input  wire        hallPhaseU,
  input  wire        hallPhaseV,
  input  wire        hallPhaseW,
  input  wire        overcurrentN,
  // switch signals
  output wire        phaseUHighSide,
  output wire        phaseUHighSideOe,
  output wire        phaseULowSide,
  output wire        phaseULowSideOe,
  output wire        phaseVHighSide,
  output wire        phaseVHighSideOe,
  output wire        phaseVLowSide,
  output wire        phaseVLowSideOe,
  output wire        phaseWHighSide,
  output wire        phaseWHighSideOe,
  output wire        phaseWLowSide,
  output wire        phaseWLowSideOe,
  // interrupt
  output wire        irq
);

  localparam        CARRIER_CYCLES = `HCPU_CARRIER_US * `HCPU_CLK_MHZ;
  localparam [31:0] CARRIER_END    = CARRIER_CYCLES - 1;
  localparam [31:0] TICK_END       = TICK_CYCLES - 1;
  localparam [31:0] STALL_END      = STALL_CYCLES - 1;
  // counters sized for the default counts, top bits dropped on purpose
  localparam [10:0] CARRIER_LAST   = CARRIER_END[10:0];
  localparam [15:0] TICK_LAST      = TICK_END[15:0];
  localparam [19:0] STALL_LAST     = STALL_END[19:0];

  // 120 degree table, returns {high[2:0], low[2:0]} with bit0 = phase U
  function [5:0] commute;
    input [2:0] hall; // {W, V, U}
    begin
      case (hall)
        3'b001:  commute = {3'b001, 3'b010};
        3'b011:  commute = {3'b001, 3'b100};
        3'b010:  commute = {3'b010, 3'b100};
        3'b110:  commute = {3'b010, 3'b001};
        3'b100:  commute = {3'b100, 3'b001};
        3'b101:  commute = {3'b100, 3'b010};
        default: commute = 6'h00;
      endcase
    end
  endfunction

  // registers
  reg  [3:0]  ctrl;
  reg  [5:0]  outSel;
  reg  [5:0]  outLevel;
  reg  [10:0] duty;
  reg  [6:0]  irqStat;
  reg  [6:0]  irqMask;
  // timers and state
  reg  [15:0] tickCnt;
  reg  [15:0] speedCnt;
  reg  [15:0] speedCap;
  reg  [10:0] carrierCnt;
  reg  [19:0] stallCnt;
  reg         stallFault;
  reg         shutdown;
  reg  [2:0]  hallPrev;
  reg         ocPrev;
  reg         hallArmed;
  reg  [5:0]  commPattern;

  wire [2:0]  hallNow = {hallPhaseW, hallPhaseV, hallPhaseU};
  // no edge on the first sample after reset: hallPrev is not the pin level
  wire [2:0]  hallEdge = (hallNow ^ hallPrev) & {3{hallArmed}};
  wire        anyHallEdge = |hallEdge;
  wire        ocFall = ocPrev & ~overcurrentN;
  wire        tickEvent = (tickCnt == TICK_LAST);
  wire        carrierEvent = (carrierCnt == CARRIER_LAST);
  wire        stallEvent = ctrl[`HCPU_CTRL_RUN] & ~stallFault &
                           (stallCnt == STALL_LAST);

  // apb decode
  wire        setup = psel & ~penable;
  wire        access = psel & penable;
  wire        wrAcc = access & pwrite;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `HCPU_ADDR_CTRL) || (a == `HCPU_ADDR_OUTSEL) ||
               (a == `HCPU_ADDR_OUTLEVEL) || (a == `HCPU_ADDR_DUTY) ||
               (a == `HCPU_ADDR_STATUS) || (a == `HCPU_ADDR_IRQSTAT) ||
               (a == `HCPU_ADDR_IRQMASK) || (a == `HCPU_ADDR_SPEEDCNT) ||
               (a == `HCPU_ADDR_SPEEDCAP);
    end
  endfunction

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped(paddr);

  wire wrCtrl = wrAcc & (paddr == `HCPU_ADDR_CTRL);
  wire sdClr  = wrCtrl & pwdata[`HCPU_CTRL_SDCLR];
  wire stClr  = wrCtrl & pwdata[`HCPU_CTRL_STCLR];

  // clear strobes are not stored, only run and auto
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl     <= `HCPU_RST_CTRL;
      outSel   <= `HCPU_RST_OUTSEL;
      outLevel <= `HCPU_RST_OUTLEVEL;
      duty     <= `HCPU_RST_DUTY;
      irqMask  <= `HCPU_RST_IRQMASK;
    end else if (wrAcc) begin
      case (paddr)
        `HCPU_ADDR_CTRL:     ctrl     <= {2'b00, pwdata[1:0]};
        `HCPU_ADDR_OUTSEL:   outSel   <= pwdata[5:0];
        `HCPU_ADDR_OUTLEVEL: outLevel <= pwdata[5:0];
        `HCPU_ADDR_DUTY:     duty     <= pwdata[10:0];
        `HCPU_ADDR_IRQMASK:  irqMask  <= pwdata[6:0];
        default:             ctrl     <= ctrl;
      endcase
    end
  end

  // read data captured in setup, stable through the access phase
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `HCPU_ADDR_CTRL:     next_prdata[3:0] = ctrl;
      `HCPU_ADDR_OUTSEL:   next_prdata[5:0] = outSel;
      `HCPU_ADDR_OUTLEVEL: next_prdata[5:0] = outLevel;
      `HCPU_ADDR_DUTY:     next_prdata[10:0] = duty;
      `HCPU_ADDR_STATUS:   next_prdata[5:0] = {~overcurrentN, stallFault,
                                               shutdown, hallNow};
      `HCPU_ADDR_IRQSTAT:  next_prdata[6:0] = irqStat;
      `HCPU_ADDR_IRQMASK:  next_prdata[6:0] = irqMask;
      `HCPU_ADDR_SPEEDCNT: next_prdata[15:0] = speedCnt;
      `HCPU_ADDR_SPEEDCAP: next_prdata[15:0] = speedCap;
      default:             next_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  // timer array: channel 0 tick, channel 1 free run
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tickCnt  <= 16'h0000;
      speedCnt <= 16'h0000;
      speedCap <= 16'h0000;
    end else begin
      tickCnt  <= tickEvent ? 16'h0000 : tickCnt + 16'h0001;
      speedCnt <= speedCnt + 16'h0001;
      if (anyHallEdge) begin
        speedCap <= speedCnt;
      end
    end
  end

  // sawtooth carrier, reset asynchronous
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      carrierCnt <= 11'h000;
    end else begin
      carrierCnt <= carrierEvent ? 11'h000 : carrierCnt + 11'h001;
    end
  end

  // duty at or above the period gives full on
  wire pwmWave = (carrierCnt < duty);

  // pwm timer pins: u0 B/D, u1 A/C, u1 B/D, lows complementary
  wire pwmUnit0OutB = pwmWave;
  wire pwmUnit0OutD = ~pwmWave;
  wire pwmUnit1OutA = pwmWave;
  wire pwmUnit1OutC = ~pwmWave;
  wire pwmUnit1OutB = pwmWave;
  wire pwmUnit1OutD = ~pwmWave;
  wire [5:0] timerOut = {pwmUnit1OutD, pwmUnit1OutB, pwmUnit1OutC,
                         pwmUnit1OutA, pwmUnit0OutD, pwmUnit0OutB};

  // edge detectors and commutation pattern
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hallPrev    <= 3'b000;
      hallArmed   <= 1'b0;
      ocPrev      <= 1'b1;
      commPattern <= 6'h00;
    end else begin
      hallPrev  <= hallNow;
      hallArmed <= 1'b1;
      ocPrev   <= overcurrentN;
      // also reload when auto mode is off so enabling starts right
      if (anyHallEdge | ~ctrl[`HCPU_CTRL_AUTO]) begin
        commPattern <= commute(hallNow);
      end
    end
  end

  // stall watchdog: counts only while driving
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stallCnt   <= 20'h00000;
      stallFault <= 1'b0;
    end else begin
      if (~ctrl[`HCPU_CTRL_RUN] | anyHallEdge | stallFault) begin
        stallCnt <= 20'h00000;
      end else begin
        stallCnt <= stallCnt + 20'h00001;
      end
      if (stallEvent) begin
        stallFault <= 1'b1;
      end else if (stClr) begin
        stallFault <= 1'b0;
      end
    end
  end

  // forced shutdown latch; a low input keeps it set over a clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shutdown <= 1'b0;
    end else if (~overcurrentN) begin
      shutdown <= 1'b1;
    end else if (sdClr) begin
      shutdown <= 1'b0;
    end
  end

  // per signal source selection
  wire       drive = ctrl[`HCPU_CTRL_RUN] & ~stallFault;
  wire       autoMode = ctrl[`HCPU_CTRL_AUTO];
  wire [5:0] pwmSrc;
  wire [5:0] switchOut;
  wire [5:0] switchOe;
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : gPhase
      // high side pwm, low side held on by static level
      assign pwmSrc[2*p]   = autoMode ? 1'b1 : outSel[2*p];
      assign pwmSrc[2*p+1] = autoMode ? 1'b0 : outSel[2*p+1];
      assign switchOut[2*p] = ~drive ? 1'b0 :
                              autoMode ? (commPattern[3+p] & pwmWave) :
                              outSel[2*p] ? timerOut[2*p] :
                              outLevel[2*p];
      assign switchOut[2*p+1] = ~drive ? 1'b0 :
                                autoMode ? commPattern[p] :
                                outSel[2*p+1] ? timerOut[2*p+1] :
                                outLevel[2*p+1];
      // only pwm pins float; port-driven pins keep driving
      assign switchOe[2*p]   = ~(shutdown & pwmSrc[2*p]);
      assign switchOe[2*p+1] = ~(shutdown & pwmSrc[2*p+1]);
    end
  endgenerate

  assign phaseUHighSide   = switchOut[0];
  assign phaseUHighSideOe = switchOe[0];
  assign phaseULowSide    = switchOut[1];
  assign phaseULowSideOe  = switchOe[1];
  assign phaseVHighSide   = switchOut[2];
  assign phaseVHighSideOe = switchOe[2];
  assign phaseVLowSide    = switchOut[3];
  assign phaseVLowSideOe  = switchOe[3];
  assign phaseWHighSide   = switchOut[4];
  assign phaseWHighSideOe = switchOe[4];
  assign phaseWLowSide    = switchOut[5];
  assign phaseWLowSideOe  = switchOe[5];

  // interrupt status, event wins over write-one clear
  wire [6:0] events = {stallEvent, ocFall, hallEdge[2], hallEdge[1],
                       hallEdge[0], carrierEvent, tickEvent};
  wire [6:0] irqClr = (wrAcc & (paddr == `HCPU_ADDR_IRQSTAT)) ?
                      pwdata[6:0] : 7'h00;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStat <= 7'h00;
    end else begin
      irqStat <= (irqStat & ~irqClr) | events;
    end
  end

  assign irq = |(irqStat & irqMask);

endmodule

// *** verification/hall_commutation_pwm_unit_tb.sv ***
// Purpose: self-checking bench for the hall commutation pwm unit
// Assumes: short tick and stall counts, zero-wait apb slave
// Notes:   read results are checked against queued notes
`timescale 1ns/1ps
`include "hcpu_defines.vh"
module hall_commutation_pwm_unit_tb;
  localparam TICK = 50;
  localparam STALL = 200;
  localparam [47:0] PAT = {6'h00, 6'h06, 6'h18, 6'h12,
                           6'h21, 6'h24, 6'h09, 6'h00};
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         spin = 1'b0;
  reg         load = 1'b0;
  reg  [2:0]  pattern = 3'h1;
  reg         ocTrip = 1'b0;
  reg  [64:0] note;
  reg  [64:0] notes[$];
  wire        pready, pslverr, irq, hallPhaseU, hallPhaseV, hallPhaseW;
  wire        overcurrentN, phaseUHighSideOe, phaseULowSideOe;
  wire        phaseVHighSideOe, phaseVLowSideOe, phaseWHighSideOe;
  wire        phaseWLowSideOe, phaseUHighSide, phaseULowSide;
  wire        phaseVHighSide, phaseVLowSide, phaseWHighSide, phaseWLowSide;
  wire [31:0] prdata;
  wire [5:0]  sw = {phaseWLowSide, phaseWHighSide, phaseVLowSide,
                    phaseVHighSide, phaseULowSide, phaseUHighSide};
  wire [5:0]  oe = {phaseWLowSideOe, phaseWHighSideOe, phaseVLowSideOe,
                    phaseVHighSideOe, phaseULowSideOe, phaseUHighSideOe};
  integer     mismatches = 0;
  integer     checks_done = 0;
  integer     seed = 64533;
  integer     i, n, k, duty, lvl, t0, tRel;
  hcpu_hall_commutation_pwm_unit #(
    .TICK_CYCLES  (TICK),
    .STALL_CYCLES (STALL)
  ) dut_u (.*);
  hcpu_bridge_model model_u (.*);
  always #20 clk = ~clk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // releases, then idles one edge so no signal is set twice at once
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] e, input err);
    begin
      notes.push_back({err, m, e});
      apb(a, 1'b0, 32'h0);
    end
  endtask
  task setHall(input [2:0] p);
    begin
      load <= 1'b1;
      pattern <= p;
      @(posedge clk);
      load <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task waitIrq;
    begin
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      note = notes.pop_front();
      chk(32'(pslverr), 32'(note[64]));
      chk(prdata & note[63:32], note[31:0]);
    end
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  initial begin
    #(40 * 60000);
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tRel = $time;
    @(posedge clk);
    rd(`HCPU_ADDR_CTRL, 32'hF, 32'h0, 1'b0);
    rd(`HCPU_ADDR_IRQMASK, 32'h7F, 32'h0, 1'b0);
    apb(12'h030, 1'b1, 32'hFFFFFFFF);
    rd(12'h030, 32'hFFFFFFFF, 32'h0, 1'b1);
    setHall(3'h5);
    rd(`HCPU_ADDR_STATUS, 32'h7, 32'h5, 1'b0);
    t0 = $time;
    setHall(3'h4);
    rd(`HCPU_ADDR_SPEEDCAP, 32'hFFFF, (t0 - tRel) / 40 + 1, 1'b0);
    rd(`HCPU_ADDR_SPEEDCNT, 32'hFFFF, ($time - tRel) / 40, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      apb(`HCPU_ADDR_IRQMASK, 1'b1, i + 1);
      apb(`HCPU_ADDR_IRQSTAT, 1'b1, 32'h7F);
      waitIrq;
      t0 = $time;
      apb(`HCPU_ADDR_IRQSTAT, 1'b1, 32'h7F);
      waitIrq;
      chk(($time - t0) / 40,
          i ? `HCPU_CARRIER_US * `HCPU_CLK_MHZ : TICK);
    end
    for (i = 0; i < 6; i = i + 1) begin
      apb(`HCPU_ADDR_IRQMASK, 1'b1, 32'h4 << (i % 3));
      apb(`HCPU_ADDR_IRQSTAT, 1'b1, 32'h7F);
      chk(32'(irq), 32'h0);
      setHall(pattern ^ (3'h1 << (i % 3)));
      chk(32'(irq), 32'h1);
    end
    duty = 1 + ({$random(seed)} % 1249);
    apb(`HCPU_ADDR_DUTY, 1'b1, duty);
    apb(`HCPU_ADDR_OUTSEL, 1'b1, 32'h3F);
    spin <= 1'b1;
    apb(`HCPU_ADDR_CTRL, 1'b1, 32'h1);
    n = 0;
    k = 0;
    repeat (1250) begin
      @(posedge clk);
      n = n + (phaseVHighSide === 1'b1);
      k = k + (phaseWLowSide === 1'b1);
    end
    chk(n, duty);
    chk(k, 1250 - duty);
    lvl = $random(seed);
    apb(`HCPU_ADDR_OUTLEVEL, 1'b1, lvl);
    apb(`HCPU_ADDR_OUTSEL, 1'b1, 32'h0);
    chk(32'(sw), lvl & 32'h3F);
    apb(`HCPU_ADDR_DUTY, 1'b1, 32'd1250);
    apb(`HCPU_ADDR_OUTSEL, 1'b1, 32'h15);
    chk(32'(sw), (lvl & 32'h2A) | 32'h15);
    spin <= 1'b0;
    apb(`HCPU_ADDR_CTRL, 1'b1, 32'h3);
    for (i = 0; i < 8; i = i + 1) begin
      setHall(i);
      chk(32'(sw), 32'(PAT[i * 6 +: 6]));
    end
    setHall(3'h1);
    repeat (STALL + 10) @(posedge clk);
    chk(32'(sw), 32'h0);
    rd(`HCPU_ADDR_STATUS, 32'h10, 32'h10, 1'b0);
    rd(`HCPU_ADDR_IRQSTAT, 32'h40, 32'h40, 1'b0);
    spin <= 1'b1;
    apb(`HCPU_ADDR_CTRL, 1'b1, 32'hB);
    rd(`HCPU_ADDR_STATUS, 32'h10, 32'h0, 1'b0);
    apb(`HCPU_ADDR_IRQMASK, 1'b1, 32'h20);
    apb(`HCPU_ADDR_IRQSTAT, 1'b1, 32'h7F);
    ocTrip <= 1'b1;
    repeat (3) @(posedge clk);
    chk({oe, irq}, 32'h55);
    ocTrip <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(oe), 32'h2A);
    apb(`HCPU_ADDR_CTRL, 1'b1, 32'h7);
    chk(32'(oe), 32'h3F);
    final_report;
  end
endmodule

// *** verification/hcpu_bridge_model.sv ***
// Purpose: hall sensors and overcurrent line of the inverter
// Assumes: hall steps every 64 clocks while spinning
// Notes:   load overrides the rotation, also with invalid codes
`timescale 1ns/1ps
module hcpu_bridge_model (
  // bench control
  input  wire       clk,
  input  wire       spin,
  input  wire       load,
  input  wire [2:0] pattern,
  input  wire       ocTrip,
  // sensor lines
  output wire       hallPhaseU,
  output wire       hallPhaseV,
  output wire       hallPhaseW,
  output wire       overcurrentN
);
  reg [5:0] div = 6'h00;
  reg [2:0] pos = 3'h1;
  assign {hallPhaseW, hallPhaseV, hallPhaseU} = pos;
  assign overcurrentN = !ocTrip;
  always @(posedge clk) begin
    div <= div + 6'h01;
    if (load) begin
      pos <= pattern;
    end else if (spin && div == 6'h3F) begin
      case (pos)
        3'h1: pos <= 3'h3;
        3'h3: pos <= 3'h2;
        3'h2: pos <= 3'h6;
        3'h6: pos <= 3'h4;
        3'h4: pos <= 3'h5;
        default: pos <= 3'h1;
      endcase
    end
  end
endmodule

// *** verification/hcpu_checker.sv ***
// Purpose: port checker for the hall commutation pwm unit
// Assumes: ctrl, outsel and mask mirrored from apb writes
// Notes:   stall bound follows the instance parameter
`timescale 1ns/1ps
`include "hcpu_defines.vh"
module hcpu_checker #(
  parameter STALL_CYCLES = 200
) (
  // clock, reset and apb
  input wire        clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // motor side
  input wire        hallPhaseU,
  input wire        hallPhaseV,
  input wire        hallPhaseW,
  input wire        overcurrentN,
  input wire        phaseUHighSide,
  input wire        phaseUHighSideOe,
  input wire        phaseULowSide,
  input wire        phaseVHighSide,
  input wire        phaseVLowSide,
  input wire        phaseWHighSide,
  input wire        phaseWLowSide,
  input wire        irq
);
  reg  [1:0]  ctrl;
  reg  [1:0]  outsel;
  reg  [1:0]  mask;
  reg  [2:0]  hallQ;
  reg  [19:0] quiet;
  wire        wr = psel && penable && pwrite;
  wire [2:0]  hall = {hallPhaseW, hallPhaseV, hallPhaseU};
  wire [5:0]  sw = {phaseWLowSide, phaseWHighSide, phaseVLowSide,
                    phaseVHighSide, phaseULowSide, phaseUHighSide};
  // any write restarts the quiet count: conservative, never early
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl   <= 2'h0;
      outsel <= 2'h0;
      mask   <= 2'h0;
      hallQ  <= 3'h0;
      quiet  <= 20'h00000;
    end else begin
      hallQ <= hall;
      if (wr && paddr == `HCPU_ADDR_CTRL) ctrl <= pwdata[1:0];
      if (wr && paddr == `HCPU_ADDR_OUTSEL) outsel <= pwdata[1:0];
      if (wr && paddr == `HCPU_ADDR_IRQMASK) mask <= {pwdata[5], pwdata[2]};
      if (!ctrl[0] || hall != hallQ || wr) quiet <= 20'h00000;
      else if (quiet != 20'hFFFFF) quiet <= quiet + 20'h00001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_hall_irq;
    $changed(hallPhaseU) && mask[0] |-> ##[1:3] irq;
  endproperty
  a_hall_irq: assert property (p_hall_irq)
    else $error("hall edge gave no irq");
  property p_oc_irq;
    $fell(overcurrentN) && mask[1] |-> ##[1:3] irq;
  endproperty
  a_oc_irq: assert property (p_oc_irq)
    else $error("overcurrent edge gave no irq");
  property p_oc_hiz;
    !overcurrentN && ctrl[1] |=> !phaseUHighSideOe;
  endproperty
  a_oc_hiz: assert property (p_oc_hiz)
    else $error("pwm pin still driven in overcurrent");
  property p_hiz_hold;
    !phaseUHighSideOe && ctrl[1] && !wr |=> !phaseUHighSideOe;
  endproperty
  a_hiz_hold: assert property (p_hiz_hold)
    else $error("shutdown left without software clear");
  property p_no_dead;
    !ctrl[1] && outsel == 2'h3 && (phaseUHighSide || phaseULowSide)
      |-> phaseUHighSide != phaseULowSide;
  endproperty
  a_no_dead: assert property (p_no_dead)
    else $error("u pair not complementary");
  property p_auto_sel;
    ctrl == 2'h3 && hall == 3'h1 && $past(hall) == 3'h1
      && $past(hall, 2) == 3'h1 |-> (sw & 6'h36) == 6'h00;
  endproperty
  a_auto_sel: assert property (p_auto_sel)
    else $error("wrong switches for pattern one");
  property p_auto_off;
    ctrl[1] && (hall == 3'h0 || hall == 3'h7) && $stable(hall)
      && $past(hall, 2) == hall |-> sw == 6'h00;
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("invalid pattern drove a switch");
  property p_stall;
    quiet > STALL_CYCLES + 3 |-> sw == 6'h00;
  endproperty
  a_stall: assert property (p_stall)
    else $error("outputs live after stall time");
  c_clear: cover property (wr && paddr == `HCPU_ADDR_IRQSTAT);
  c_trip: cover property (!overcurrentN && ctrl[1]);
  c_stall: cover property (quiet > STALL_CYCLES);
endmodule
bind hcpu_hall_commutation_pwm_unit hcpu_checker #(
  .STALL_CYCLES (STALL_CYCLES)
) chk_u (.*);
